// file: uec_params.svh
// register offsets, field positions, reset values and counts of the endpoint-0 block
`ifndef UEC_PARAMS_SVH
`define UEC_PARAMS_SVH

`define UEC_OFF_CSR          4'h0
`define UEC_OFF_IRQ_STATUS   4'h4
`define UEC_OFF_IRQ_MASK     4'h8

`define UEC_BIT_EARLY_ACK    23
`define UEC_BIT_RX_SVC_ACK   22
`define UEC_BIT_B21          21
`define UEC_BIT_B20          20
`define UEC_BIT_B19          19
`define UEC_BIT_B18          18
`define UEC_BIT_TX_RDY       17
`define UEC_BIT_RX_RDY       16
`define UEC_CSR_LANE         2

`define UEC_IRQ_EARLY_END    0
`define UEC_IRQ_NO_RESP      1
`define UEC_IRQ_STALL        2
`define UEC_IRQ_RX_RDY       3
`define UEC_IRQ_TX_DONE      4
`define UEC_IRQ_WIDTH        5

`define UEC_CSR_RESET        6'h00
`define UEC_IRQ_MASK_RESET   5'h00
`define UEC_NO_RESP_LIMIT    2'h3

`endif

// file: uec_pkg.sv
// types shared by the endpoint-0 control and status logic
package uec_pkg;

  typedef enum logic [1:0] {
    UEC_BUS_IDLE = 2'b01,
    UEC_BUS_ACK  = 2'b10
  } uec_bus_t;

  typedef struct packed {
    uec_bus_t    bus;
    logic        waitreq;
    logic [31:0] rdata;
    logic        b21;
    logic        b20;
    logic        b19;
    logic        b18;
    logic        tx_rdy;
    logic        rx_rdy;
    logic        stall_abort;
    logic        tx_setup;
    logic        toggle_reset;
    logic        fifo_flush;
    logic        stall_req;
    logic        in_req;
  } uec_csr_state_t;

  typedef struct packed {
    logic [4:0] status;
    logic [4:0] mask;
    logic       irq;
  } uec_irq_state_t;

  typedef struct packed {
    logic [1:0] misses;
    logic       err;
  } uec_retry_state_t;

endpackage

// file: uec_irq.sv
// sticky event status, mask and the level interrupt output
`timescale 1ns/100ps
`include "uec_params.svh"
module uec_irq
  import uec_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic [`UEC_IRQ_WIDTH-1:0] event_set,
  input  wire logic                      status_wr,
  input  wire logic                      mask_wr,
  input  wire logic [`UEC_IRQ_WIDTH-1:0] wdata,
  output logic      [`UEC_IRQ_WIDTH-1:0] status,
  output logic      [`UEC_IRQ_WIDTH-1:0] mask,
  output logic                           irq
);

  uec_irq_state_t s_reg;
  uec_irq_state_t s_next;

  always_comb begin
    s_next = s_reg;
    // a clearing write never loses an event of the same cycle
    if (status_wr) begin
      s_next.status = s_reg.status & ~wdata;
    end
    s_next.status = s_next.status | event_set;
    if (mask_wr) begin
      s_next.mask = wdata;
    end
    s_next.irq = |(s_next.status & s_next.mask);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{status: 5'h00, mask: `UEC_IRQ_MASK_RESET, irq: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign status = s_reg.status;
  assign mask   = s_reg.mask;
  assign irq    = s_reg.irq;

endmodule

// file: uec_retry.sv
// counts unanswered host transaction attempts and flags the third in a row
`timescale 1ns/100ps
`include "uec_params.svh"
module uec_retry
  import uec_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic host_mode,
  input  wire logic attempt_timeout,
  input  wire logic attempt_answered,
  output logic      no_resp_err
);

  uec_retry_state_t s_reg;
  uec_retry_state_t s_next;

  always_comb begin
    s_next     = s_reg;
    s_next.err = 1'b0;
    if (!host_mode || attempt_answered) begin
      s_next.misses = 2'h0;
    end else if (attempt_timeout) begin
      if (s_reg.misses == `UEC_NO_RESP_LIMIT - 2'h1) begin
        s_next.err    = 1'b1;
        s_next.misses = 2'h0;
      end else begin
        s_next.misses = s_reg.misses + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{misses: 2'h0, err: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign no_resp_err = s_reg.err;

endmodule

// file: uec_ep0_csr.sv
// endpoint-0 control/status word with Avalon-MM slave, interrupts and engine handshakes
//
// Operation
// - device stall request aborts, sends STALL, self-clears
// - host IN request clears when receive ready sets
// - early control end sets flag, interrupts, flushes FIFO
// - early-end flag clears only by ack write
// - three unanswered host attempts set error, interrupt
// - hardware alone clears data-end bit
// - host SETUP-select with transmit ready sends SETUP
// - setting SETUP-select resets data toggle
// - device flags stall sent, software clears
// - host flags stall received, software clears
// - transmit ready cleared once packet handled
// - receive ready sets on packet, may interrupt
// - receive-serviced write clears receive ready
// - low sixteen bits always read zero
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`include "uec_params.svh"
module uec_ep0_csr
  import uec_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Avalon-MM slave, word addressed
  input  wire logic [1:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // role select from the controller
  input  wire logic        host_mode,
  // events from the packet engine, one-cycle pulses
  input  wire logic        eng_stall_sent,
  input  wire logic        eng_stall_rcvd,
  input  wire logic        eng_tx_done,
  input  wire logic        eng_rx_pkt,
  input  wire logic        eng_ctrl_end,
  input  wire logic        eng_data_end_done,
  input  wire logic        eng_attempt_timeout,
  input  wire logic        eng_attempt_answered,
  // commands to the packet engine, and the interrupt output
  output logic             stall_request,
  output logic             stall_abort,
  output logic             in_transfer_request,
  output logic             tx_packet_ready,
  output logic             tx_token_setup,
  output logic             data_toggle_reset,
  output logic             fifo_flush,
  output logic             irq
);

  uec_csr_state_t s_reg;
  uec_csr_state_t s_next;

  logic [`UEC_IRQ_WIDTH-1:0] irq_events;
  logic [`UEC_IRQ_WIDTH-1:0] irq_status;
  logic [`UEC_IRQ_WIDTH-1:0] irq_mask;
  logic                      no_resp_err;
  logic                      wr_take;
  logic                      csr_wr;
  logic                      status_wr;
  logic                      mask_wr;
  logic [7:0]                wr_lane;
  logic [31:0]               rd_value;
  logic                      ev_early;
  logic                      ev_stall;

  function automatic logic [1:0] uec_word(input logic [3:0] byte_off);
    uec_word = byte_off[3:2];
  endfunction

  function automatic logic lane_bit(input logic [7:0] lane, input int pos);
    lane_bit = lane[pos - 16];
  endfunction

  // writes land on the edge where the master sees waitrequest low
  assign wr_take   = avs_write && (s_reg.bus == UEC_BUS_ACK);
  assign csr_wr    = wr_take && (avs_address == uec_word(`UEC_OFF_CSR))
                     && avs_byteenable[`UEC_CSR_LANE];
  assign status_wr = wr_take && (avs_address == uec_word(`UEC_OFF_IRQ_STATUS))
                     && avs_byteenable[0];
  assign mask_wr   = wr_take && (avs_address == uec_word(`UEC_OFF_IRQ_MASK))
                     && avs_byteenable[0];
  assign wr_lane   = avs_writedata[23:16];

  assign ev_early  = !host_mode && eng_ctrl_end && !s_reg.b19;
  assign ev_stall  = host_mode ? eng_stall_rcvd : eng_stall_sent;

  always_comb begin
    rd_value = 32'h0000_0000;
    if (avs_address == uec_word(`UEC_OFF_CSR)) begin
      // low half and the ack strobes read as zero
      rd_value[`UEC_BIT_B21]    = s_reg.b21;
      rd_value[`UEC_BIT_B20]    = s_reg.b20;
      rd_value[`UEC_BIT_B19]    = s_reg.b19;
      rd_value[`UEC_BIT_B18]    = s_reg.b18;
      rd_value[`UEC_BIT_TX_RDY] = s_reg.tx_rdy;
      rd_value[`UEC_BIT_RX_RDY] = s_reg.rx_rdy;
    end else if (avs_address == uec_word(`UEC_OFF_IRQ_STATUS)) begin
      rd_value[`UEC_IRQ_WIDTH-1:0] = irq_status;
    end else if (avs_address == uec_word(`UEC_OFF_IRQ_MASK)) begin
      rd_value[`UEC_IRQ_WIDTH-1:0] = irq_mask;
    end
  end

  always_comb begin
    s_next              = s_reg;
    s_next.stall_abort  = 1'b0;
    s_next.toggle_reset = 1'b0;
    s_next.fifo_flush   = 1'b0;

    // bus handshake: one wait cycle, then one cycle with waitrequest low
    unique case (s_reg.bus)
      UEC_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          s_next.bus     = UEC_BUS_ACK;
          s_next.waitreq = 1'b0;
          s_next.rdata   = avs_read ? rd_value : 32'h0000_0000;
        end
      end
      UEC_BUS_ACK: begin
        s_next.bus     = UEC_BUS_IDLE;
        s_next.waitreq = 1'b1;
      end
    endcase

    // software side of the control/status word
    if (csr_wr) begin
      if (host_mode) begin
        s_next.b21 = lane_bit(wr_lane, `UEC_BIT_B21);
        if (!lane_bit(wr_lane, `UEC_BIT_B20)) begin
          s_next.b20 = 1'b0;
        end
        s_next.b19 = lane_bit(wr_lane, `UEC_BIT_B19);
        if (lane_bit(wr_lane, `UEC_BIT_B19)) begin
          s_next.toggle_reset = 1'b1;
        end
      end else begin
        if (lane_bit(wr_lane, `UEC_BIT_B21)) begin
          s_next.b21         = 1'b1;
          s_next.stall_abort = !s_reg.b21;
        end
        if (lane_bit(wr_lane, `UEC_BIT_EARLY_ACK)) begin
          s_next.b20 = 1'b0;
        end
        if (lane_bit(wr_lane, `UEC_BIT_B19)) begin
          s_next.b19 = 1'b1;
        end
      end
      if (!lane_bit(wr_lane, `UEC_BIT_B18)) begin
        s_next.b18 = 1'b0;
      end
      if (lane_bit(wr_lane, `UEC_BIT_TX_RDY)) begin
        s_next.tx_rdy = 1'b1;
      end
      if (lane_bit(wr_lane, `UEC_BIT_RX_SVC_ACK)) begin
        s_next.rx_rdy = 1'b0;
      end
    end

    // engine events come after the software writes so that the engine event wins
    if (!host_mode && eng_stall_sent) begin
      s_next.b21 = 1'b0;
    end
    if (host_mode && eng_rx_pkt) begin
      s_next.b21 = 1'b0;
    end
    if (ev_early) begin
      s_next.b20        = 1'b1;
      s_next.fifo_flush = 1'b1;
    end
    if (host_mode && no_resp_err) begin
      s_next.b20 = 1'b1;
    end
    if (!host_mode && (eng_data_end_done || eng_ctrl_end)) begin
      s_next.b19 = 1'b0;
    end
    if (ev_stall) begin
      s_next.b18 = 1'b1;
    end
    if (eng_tx_done) begin
      s_next.tx_rdy = 1'b0;
    end
    if (eng_rx_pkt) begin
      s_next.rx_rdy = 1'b1;
    end

    // token choice follows SETUP-select and transmit ready on every cycle
    s_next.tx_setup = host_mode && s_next.b19 && s_next.tx_rdy;
    // role split registered so both request outputs leave a flop
    s_next.stall_req = s_next.b21 && !host_mode;
    s_next.in_req    = s_next.b21 && host_mode;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg.bus          <= UEC_BUS_IDLE;
      s_reg.waitreq      <= 1'b1;
      s_reg.rdata        <= 32'h0000_0000;
      {s_reg.b21, s_reg.b20, s_reg.b19, s_reg.b18, s_reg.tx_rdy, s_reg.rx_rdy}
                         <= `UEC_CSR_RESET;
      s_reg.stall_abort  <= 1'b0;
      s_reg.tx_setup     <= 1'b0;
      s_reg.toggle_reset <= 1'b0;
      s_reg.fifo_flush   <= 1'b0;
      s_reg.stall_req    <= 1'b0;
      s_reg.in_req       <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  always_comb begin
    irq_events                       = '0;
    irq_events[`UEC_IRQ_EARLY_END]   = ev_early;
    irq_events[`UEC_IRQ_NO_RESP]     = host_mode && no_resp_err;
    irq_events[`UEC_IRQ_STALL]       = ev_stall;
    irq_events[`UEC_IRQ_RX_RDY]      = eng_rx_pkt;
    irq_events[`UEC_IRQ_TX_DONE]     = eng_tx_done;
  end

  uec_irq u_irq (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .event_set (irq_events),
    .status_wr (status_wr),
    .mask_wr   (mask_wr),
    .wdata     (avs_writedata[`UEC_IRQ_WIDTH-1:0]),
    .status    (irq_status),
    .mask      (irq_mask),
    .irq       (irq)
  );

  uec_retry u_retry (
    .sys_clk          (sys_clk),
    .rst_n            (rst_n),
    .host_mode        (host_mode),
    .attempt_timeout  (eng_attempt_timeout),
    .attempt_answered (eng_attempt_answered),
    .no_resp_err      (no_resp_err)
  );

  assign avs_readdata        = s_reg.rdata;
  assign avs_waitrequest     = s_reg.waitreq;
  // stall and IN requests share bit 21, split by role
  assign stall_request       = s_reg.stall_req;
  assign in_transfer_request = s_reg.in_req;
  assign stall_abort         = s_reg.stall_abort;
  assign tx_packet_ready     = s_reg.tx_rdy;
  assign tx_token_setup      = s_reg.tx_setup;
  assign data_toggle_reset   = s_reg.toggle_reset;
  assign fifo_flush          = s_reg.fifo_flush;

endmodule

// file: uec_ep0_csr_assertions.sv
// port assertions for the endpoint-0 control/status block
`timescale 1ns/100ps
module uec_ep0_csr_chk (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [1:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        host_mode,
  input wire logic        eng_stall_sent,
  input wire logic        eng_rx_pkt,
  input wire logic        eng_tx_done,
  input wire logic        eng_ctrl_end,
  input wire logic        stall_request,
  input wire logic        stall_abort,
  input wire logic        in_transfer_request,
  input wire logic        tx_packet_ready,
  input wire logic        tx_token_setup,
  input wire logic        data_toggle_reset,
  input wire logic        fifo_flush
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_BUS_ACK: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered after one wait cycle");
  AST_LOW_ZERO: assert property (!avs_waitrequest && avs_read && avs_address == 2'h0
    |-> avs_readdata[15:0] == 16'h0 && avs_readdata[31:24] == 8'h0)
    else $error("unimplemented bits read nonzero");
  AST_ABORT: assert property ($rose(stall_request) |-> ##[0:1] stall_abort)
    else $error("stall request without abort");
  AST_STALL_CLR: assert property (eng_stall_sent && !host_mode |=> !stall_request)
    else $error("stall request not cleared");
  AST_IN_CLR: assert property (eng_rx_pkt && host_mode |=> !in_transfer_request)
    else $error("in request not cleared on receive");
  AST_TX_CLR: assert property (eng_tx_done && !avs_write |=> !tx_packet_ready)
    else $error("tx ready not cleared");
  AST_SETUP: assert property (tx_token_setup |-> tx_packet_ready && host_mode)
    else $error("setup token without host tx ready");
  AST_FLUSH: assert property (fifo_flush |-> $past(eng_ctrl_end) && !$past(host_mode))
    else $error("flush without device control end");
  AST_TOGGLE: assert property (data_toggle_reset |-> $past(avs_write) && $past(host_mode)
    && $past(avs_writedata[19]) && !$past(avs_waitrequest) && $past(avs_address) == 2'h0)
    else $error("toggle reset without setup select write");
  cover property (stall_abort);
  cover property (data_toggle_reset);
  cover property (fifo_flush);
endmodule
bind uec_ep0_csr uec_ep0_csr_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .host_mode(host_mode), .eng_stall_sent(eng_stall_sent),
  .eng_rx_pkt(eng_rx_pkt), .eng_tx_done(eng_tx_done), .eng_ctrl_end(eng_ctrl_end),
  .stall_request(stall_request), .stall_abort(stall_abort),
  .in_transfer_request(in_transfer_request), .tx_packet_ready(tx_packet_ready),
  .tx_token_setup(tx_token_setup), .data_toggle_reset(data_toggle_reset),
  .fifo_flush(fifo_flush));

// file: uec_eng_model.sv
// packet engine stand-in answering stall, in and tx commands
`timescale 1ns/100ps
module uec_eng_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] dly,
  input  wire logic       stall_request,
  input  wire logic       in_transfer_request,
  input  wire logic       tx_packet_ready,
  output logic            eng_stall_sent,
  output logic            eng_rx_pkt,
  output logic            eng_tx_done
);
  logic [4:0] cnt;
  logic [2:0] ev;
  logic [2:0] req;
  assign req = {stall_request, in_transfer_request, tx_packet_ready};
  assign {eng_stall_sent, eng_rx_pkt, eng_tx_done} = ev;
  // cooldown after a pulse so a request is never answered twice
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 5'h0;
      ev  <= 3'h0;
    end else begin
      ev <= 3'h0;
      if (cnt == 5'h0 && |req) cnt <= {1'b0, dly} + 5'h2;
      else if (cnt != 5'h0) cnt <= cnt - 5'h1;
      if (cnt == 5'h2 && |req) ev <= req[2] ? 3'h4 : (req[1] ? 3'h2 : 3'h1);
    end
  end
endmodule

// file: test_uec_ep0_csr.sv
// self-checking bench for the endpoint-0 control/status block
`timescale 1ns/100ps
module test_uec_ep0_csr;
  logic        sys_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, host_mode = 0;
  logic [1:0]  avs_address = 0;
  logic [3:0]  be = 4'hf, dly = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, m, seed = 32'h139804d7;
  logic        avs_waitrequest, irq, stall_sent, rx_pkt, tx_done, stall_request, stall_abort;
  logic        in_req, tx_rdy, tx_setup, tog, flush, seen_f = 0, seen_t = 0;
  logic [4:0]  ev = 0;
  int          mismatches = 0, samples_checked = 0;
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
  uec_ep0_csr u_uec_ep0_csr (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(be),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .host_mode(host_mode), .eng_stall_sent(stall_sent),
    .eng_stall_rcvd(ev[4]), .eng_tx_done(tx_done), .eng_rx_pkt(rx_pkt), .eng_ctrl_end(ev[3]),
    .eng_data_end_done(ev[2]), .eng_attempt_timeout(ev[1]), .eng_attempt_answered(ev[0]),
    .stall_request(stall_request), .stall_abort(stall_abort), .in_transfer_request(in_req),
    .tx_packet_ready(tx_rdy), .tx_token_setup(tx_setup), .data_toggle_reset(tog),
    .fifo_flush(flush), .irq(irq));
  uec_eng_model u_uec_eng_model (.sys_clk(sys_clk), .rst_n(rst_n), .dly(dly),
    .stall_request(stall_request), .in_transfer_request(in_req), .tx_packet_ready(tx_rdy),
    .eng_stall_sent(stall_sent), .eng_rx_pkt(rx_pkt), .eng_tx_done(tx_done));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (flush) seen_f <= 1'b1;
    if (tog) seen_t <= 1'b1;
  end
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task bus(input logic w, input logic [1:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge sys_clk);
    // waits for waitrequest low; only the watchdog limits this wait
    while (avs_waitrequest !== 1'b0) begin
      @(posedge sys_clk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task wr(input logic [1:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rdc(input string n, input logic [1:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(n, e, q)
  endtask
  task evp(input logic [4:0] v);
    ev <= v;
    @(posedge sys_clk);
    ev <= 5'h0;
    @(posedge sys_clk);
  endtask
  task idle();
    int n;
    n = 0;
    while ((stall_request | in_req | tx_rdy) !== 1'b0 && n < 60) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (2) @(posedge sys_clk);
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rdc("csr", 2'h0, 32'h0);
    wr(2'h3, 32'hffffffff);
    rdc("unmapped", 2'h3, 32'h0);
    be <= 4'h0;
    wr(2'h2, 32'h1f);
    be <= 4'hf;
    rdc("lane", 2'h2, 32'h0);
    for (int i = 0; i < 4; i++) begin
      m = xs();
      wr(2'h2, m);
      rdc("mask", 2'h2, m & 32'h1f);
    end
    wr(2'h2, 32'h0);
    dly <= 4'(xs());
    wr(2'h0, 32'h0020_0000);
    idle();
    rdc("stall", 2'h0, 32'h0004_0000);
    rdc("status", 2'h1, 32'h4);
    wr(2'h2, 32'h4);
    `CHK("irq", 1'b1, irq)
    wr(2'h1, 32'h4);
    `CHK("irq", 1'b0, irq)
    wr(2'h0, 32'h0);
    rdc("stall", 2'h0, 32'h0);
    wr(2'h0, 32'h000a_0000);
    idle();
    rdc("tx", 2'h0, 32'h0008_0000);
    wr(2'h0, 32'h0);
    rdc("dend", 2'h0, 32'h0008_0000);
    evp(5'h04);
    rdc("dend", 2'h0, 32'h0);
    evp(5'h08);
    rdc("early", 2'h0, 32'h0010_0000);
    `CHK("flush", 1'b1, seen_f)
    wr(2'h0, 32'h0);
    rdc("early", 2'h0, 32'h0010_0000);
    wr(2'h0, 32'h0080_0000);
    rdc("early", 2'h0, 32'h0);
    wr(2'h0, 32'h0008_0000);
    evp(5'h08);
    rdc("early", 2'h0, 32'h0);
    host_mode <= 1'b1;
    wr(2'h1, 32'h1f);
    dly <= 4'(xs());
    wr(2'h0, 32'h0020_0000);
    idle();
    rdc("in", 2'h0, 32'h0001_0000);
    rdc("status", 2'h1, 32'h8);
    wr(2'h0, 32'h0040_0000);
    rdc("in", 2'h0, 32'h0);
    repeat (2) evp(5'h02);
    evp(5'h01);
    repeat (2) evp(5'h02);
    rdc("noresp", 2'h0, 32'h0);
    evp(5'h02);
    rdc("noresp", 2'h0, 32'h0010_0000);
    wr(2'h0, 32'h0010_0000);
    rdc("noresp", 2'h0, 32'h0010_0000);
    wr(2'h0, 32'h0);
    rdc("noresp", 2'h0, 32'h0);
    dly <= 4'hf;
    wr(2'h0, 32'h0002_0000);
    `CHK("out", 1'b0, tx_setup)
    `CHK("tog", 1'b0, seen_t)
    idle();
    wr(2'h0, 32'h000a_0000);
    `CHK("setup", 1'b1, tx_setup)
    // the seen flag settles one edge after the toggle pulse
    idle();
    `CHK("tog", 1'b1, seen_t)
    rdc("setup", 2'h0, 32'h0008_0000);
    evp(5'h10);
    rdc("stall_received_flag", 2'h0, 32'h000c_0000);
    summarize();
  end
endmodule
